// ===== logic/ram_addr_pkg.sv
// Constants for the display RAM address counter: command codes, field
// positions, reset values and widths.
// Assumes bytes arrive already deserialised on the controller clock.
package ram_addr_pkg;

    localparam int XW = 6;
    localparam int YW = 9;
    localparam int MODE_W = 3;

    // Command codes
    localparam logic [7:0] CMD_ENTRY_MODE = 8'h11;
    localparam logic [7:0] CMD_HORIZ_WIN = 8'h44;
    localparam logic [7:0] CMD_VERT_WIN = 8'h45;
    localparam logic [7:0] CMD_HORIZ_POS = 8'h4e;
    localparam logic [7:0] CMD_VERT_POS = 8'h4f;
    localparam logic [7:0] CMD_NO_OPERATION = 8'h7f;
    // Frame memory write commands for the two planes
    localparam logic [7:0] CMD_WRITE_PLANE0 = 8'h24;
    localparam logic [7:0] CMD_WRITE_PLANE1 = 8'h26;

    // Field positions inside the data-entry byte
    localparam int SIGN_X_BIT = 0;
    localparam int SIGN_Y_BIT = 1;
    localparam int AXIS_BIT = 2;

    // Parameter byte indices
    localparam logic [1:0] PIDX_0 = 2'h0;
    localparam logic [1:0] PIDX_1 = 2'h1;
    localparam logic [1:0] PIDX_2 = 2'h2;
    localparam logic [1:0] PIDX_3 = 2'h3;

    // Values after reset
    localparam logic [MODE_W-1:0] RST_ENTRY_MODE = 3'h3;
    localparam logic [XW-1:0] RST_HORIZ_POS = 6'h00;
    localparam logic [YW-1:0] RST_VERT_POS = 9'h000;
    localparam logic [XW-1:0] RST_HORIZ_START = 6'h00;
    localparam logic [XW-1:0] RST_HORIZ_END = 6'h15;
    localparam logic [YW-1:0] RST_VERT_START = 9'h000;
    localparam logic [YW-1:0] RST_VERT_END = 9'h127;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PARAM = 2'b01,
        ST_WRITE = 2'b10
    } parse_state_t;

endpackage

// ===== logic/step_if.sv
// Carries the current counter, window and entry setting to the stepper
// and the stepped position back. The stepper end holds no state; only the controller end is clocked.
interface step_if;
    logic [ram_addr_pkg::XW-1:0] cur_x;
    logic [ram_addr_pkg::YW-1:0] cur_y;
    logic [ram_addr_pkg::MODE_W-1:0] mode;
    logic [ram_addr_pkg::XW-1:0] x_start;
    logic [ram_addr_pkg::XW-1:0] x_end;
    logic [ram_addr_pkg::YW-1:0] y_start;
    logic [ram_addr_pkg::YW-1:0] y_end;
    logic [ram_addr_pkg::XW-1:0] nxt_x;
    logic [ram_addr_pkg::YW-1:0] nxt_y;

    modport ctrl (output cur_x, cur_y, mode, x_start, x_end, y_start, y_end, input nxt_x, nxt_y);
    modport stepper (input cur_x, cur_y, mode, x_start, x_end, y_start, y_end, output nxt_x, nxt_y);
endinterface

// ===== logic/window_stepper.sv
// Computes the position that follows one RAM data write inside the window.
// Purely combinational; the caller registers the result.
module window_stepper (
    step_if.stepper s
);
    logic inc_x;
    logic inc_y;
    logic x_at;
    logic y_at;
    logic [ram_addr_pkg::XW-1:0] x_step;
    logic [ram_addr_pkg::XW-1:0] x_reload;
    logic [ram_addr_pkg::YW-1:0] y_step;
    logic [ram_addr_pkg::YW-1:0] y_reload;

    always_comb begin
        inc_x = s.mode[ram_addr_pkg::SIGN_X_BIT]; // [RULE7]
        inc_y = s.mode[ram_addr_pkg::SIGN_Y_BIT]; // [RULE7]
        // Increment runs start to end, decrement runs end to start
        x_step = inc_x ? s.cur_x + 6'h01 : s.cur_x - 6'h01; // [RULE5] [RULE6]
        y_step = inc_y ? s.cur_y + 9'h001 : s.cur_y - 9'h001; // [RULE5] [RULE6]
        x_at = inc_x ? (s.cur_x == s.x_end) : (s.cur_x == s.x_start); // [RULE9]
        y_at = inc_y ? (s.cur_y == s.y_end) : (s.cur_y == s.y_start); // [RULE9]
        x_reload = inc_x ? s.x_start : s.x_end;
        y_reload = inc_y ? s.y_start : s.y_end;
        if (!s.mode[ram_addr_pkg::AXIS_BIT]) begin // [RULE8]
            if (x_at) begin // [RULE12]
                s.nxt_x = x_reload;
                s.nxt_y = y_at ? y_reload : y_step;
            end else begin
                s.nxt_x = x_step;
                s.nxt_y = s.cur_y;
            end
        end else begin
            if (y_at) begin // [RULE12]
                s.nxt_y = y_reload;
                s.nxt_x = x_at ? x_reload : x_step;
            end else begin
                s.nxt_y = y_step;
                s.nxt_x = s.cur_x;
            end
        end
    end
endmodule

// ===== logic/ram_position_counter.sv
// Command decoder and RAM address counter of the display controller.
// Assumes bytes arrive as one-cycle strobes from a serial receiver on clk,
// with the data/command level captured alongside each byte.

// Overview of operation
// [RULE1] Command 4Eh plus one byte loads the six-bit horizontal position; resets zero.
// [RULE2] Command 4Fh plus low byte then bit 8 loads the nine-bit vertical position.
// [RULE3] Command 7Fh changes nothing but ends any RAM write sequence.
// [RULE4] Command 11h byte: bit 2 step axis, bits 1..0 step signs; resets to 011.
// [RULE5] A sign bit of one increments that axis after each RAM data write.
// [RULE6] A sign bit of zero decrements that axis after each RAM data write.
// [RULE7] Sign bit 0 governs horizontal, sign bit 1 governs vertical, independently.
// [RULE8] Axis select 0 advances horizontal first, 1 advances vertical first.
// [RULE9] RAM data writes stay inside the programmed window rectangle.
// [RULE10] Command 44h with two bytes sets horizontal window start and end.
// [RULE11] Command 45h with four bytes sets vertical window start and end, low first.
// [RULE12] Passing a window limit reloads that coordinate and steps the other once.
// [RULE13] Host sends commands with select low, parameters with select high, right after.
module ram_position_counter (
    input wire logic clk,
    input wire logic rstn,
    input wire logic byte_valid,
    input wire logic [7:0] byte_data,
    input wire logic byte_is_data,
    output logic ram_wr,
    output logic ram_wr_plane,
    output logic [7:0] ram_wr_data,
    output logic [ram_addr_pkg::XW-1:0] ram_wr_x,
    output logic [ram_addr_pkg::YW-1:0] ram_wr_y,
    output logic [ram_addr_pkg::XW-1:0] horiz_pos,
    output logic [ram_addr_pkg::YW-1:0] vert_pos,
    output logic [ram_addr_pkg::MODE_W-1:0] entry_mode,
    output logic write_active
);
    ram_addr_pkg::parse_state_t state_r;
    ram_addr_pkg::parse_state_t state_nxt;
    logic [7:0] cmd_r;
    logic [7:0] cmd_nxt;
    logic [1:0] pidx_r;
    logic [1:0] pidx_nxt;
    logic [ram_addr_pkg::XW-1:0] x_r;
    logic [ram_addr_pkg::XW-1:0] x_nxt;
    logic [ram_addr_pkg::YW-1:0] y_r;
    logic [ram_addr_pkg::YW-1:0] y_nxt;
    logic [ram_addr_pkg::MODE_W-1:0] mode_r;
    logic [ram_addr_pkg::MODE_W-1:0] mode_nxt;
    logic [ram_addr_pkg::XW-1:0] xs_r;
    logic [ram_addr_pkg::XW-1:0] xs_nxt;
    logic [ram_addr_pkg::XW-1:0] xe_r;
    logic [ram_addr_pkg::XW-1:0] xe_nxt;
    logic [ram_addr_pkg::YW-1:0] ys_r;
    logic [ram_addr_pkg::YW-1:0] ys_nxt;
    logic [ram_addr_pkg::YW-1:0] ye_r;
    logic [ram_addr_pkg::YW-1:0] ye_nxt;
    logic plane_r;
    logic plane_nxt;
    logic wr_r;
    logic wr_nxt;
    logic [7:0] wdata_r;
    logic [7:0] wdata_nxt;
    logic [ram_addr_pkg::XW-1:0] wx_r;
    logic [ram_addr_pkg::XW-1:0] wx_nxt;
    logic [ram_addr_pkg::YW-1:0] wy_r;
    logic [ram_addr_pkg::YW-1:0] wy_nxt;
    logic wr_open_r;
    logic wr_open_nxt;

    step_if st ();

    assign st.cur_x = x_r;
    assign st.cur_y = y_r;
    assign st.mode = mode_r;
    assign st.x_start = xs_r;
    assign st.x_end = xe_r;
    assign st.y_start = ys_r;
    assign st.y_end = ye_r;

    window_stepper u_stepper (
        .s(st.stepper)
    );

    // Parser and configuration next state
    always_comb begin
        state_nxt = state_r;
        cmd_nxt = cmd_r;
        pidx_nxt = pidx_r;
        x_nxt = x_r;
        y_nxt = y_r;
        mode_nxt = mode_r;
        xs_nxt = xs_r;
        xe_nxt = xe_r;
        ys_nxt = ys_r;
        ye_nxt = ye_r;
        plane_nxt = plane_r;
        wr_nxt = 1'b0;
        wdata_nxt = wdata_r;
        wx_nxt = wx_r;
        wy_nxt = wy_r;
        if (byte_valid && !byte_is_data) begin // [RULE13]
            // Any command byte closes a RAM write sequence in progress
            cmd_nxt = byte_data;
            pidx_nxt = ram_addr_pkg::PIDX_0;
            if (byte_data == ram_addr_pkg::CMD_NO_OPERATION) begin
                state_nxt = ram_addr_pkg::ST_IDLE; // [RULE3]
            end else if (byte_data == ram_addr_pkg::CMD_WRITE_PLANE0 ||
                         byte_data == ram_addr_pkg::CMD_WRITE_PLANE1) begin
                state_nxt = ram_addr_pkg::ST_WRITE;
                plane_nxt = (byte_data == ram_addr_pkg::CMD_WRITE_PLANE1);
            end else begin
                state_nxt = ram_addr_pkg::ST_PARAM;
            end
        end else if (byte_valid) begin
            unique case (state_r)
                ram_addr_pkg::ST_IDLE: begin
                    // Stray data with no open command is dropped
                    state_nxt = ram_addr_pkg::ST_IDLE;
                end
                ram_addr_pkg::ST_WRITE: begin
                    wr_nxt = 1'b1;
                    wdata_nxt = byte_data;
                    wx_nxt = x_r;
                    wy_nxt = y_r;
                    x_nxt = st.nxt_x; // [RULE5] [RULE6] [RULE9]
                    y_nxt = st.nxt_y; // [RULE5] [RULE6] [RULE9]
                end
                ram_addr_pkg::ST_PARAM: begin
                    // Saturate at index 3; surplus bytes of 45h keep rewriting bit 8 of the vertical end, others land on no field
                    if (pidx_r != ram_addr_pkg::PIDX_3) begin
                        pidx_nxt = pidx_r + 2'h1;
                    end
                    unique case (cmd_r)
                        ram_addr_pkg::CMD_HORIZ_POS: begin
                            if (pidx_r == ram_addr_pkg::PIDX_0) begin
                                x_nxt = byte_data[ram_addr_pkg::XW-1:0]; // [RULE1]
                            end
                        end
                        ram_addr_pkg::CMD_VERT_POS: begin
                            if (pidx_r == ram_addr_pkg::PIDX_0) begin
                                y_nxt = {y_r[8], byte_data}; // [RULE2]
                            end else if (pidx_r == ram_addr_pkg::PIDX_1) begin
                                y_nxt = {byte_data[0], y_r[7:0]}; // [RULE2]
                            end
                        end
                        ram_addr_pkg::CMD_ENTRY_MODE: begin
                            if (pidx_r == ram_addr_pkg::PIDX_0) begin
                                mode_nxt = byte_data[ram_addr_pkg::MODE_W-1:0]; // [RULE4]
                            end
                        end
                        ram_addr_pkg::CMD_HORIZ_WIN: begin
                            if (pidx_r == ram_addr_pkg::PIDX_0) begin
                                xs_nxt = byte_data[ram_addr_pkg::XW-1:0]; // [RULE10]
                            end else if (pidx_r == ram_addr_pkg::PIDX_1) begin
                                xe_nxt = byte_data[ram_addr_pkg::XW-1:0]; // [RULE10]
                            end
                        end
                        ram_addr_pkg::CMD_VERT_WIN: begin
                            if (pidx_r == ram_addr_pkg::PIDX_0) begin
                                ys_nxt = {ys_r[8], byte_data}; // [RULE11]
                            end else if (pidx_r == ram_addr_pkg::PIDX_1) begin
                                ys_nxt = {byte_data[0], ys_r[7:0]}; // [RULE11]
                            end else if (pidx_r == ram_addr_pkg::PIDX_2) begin
                                ye_nxt = {ye_r[8], byte_data}; // [RULE11]
                            end else begin
                                if (pidx_r == ram_addr_pkg::PIDX_3 && cmd_r == ram_addr_pkg::CMD_VERT_WIN) begin
                                    ye_nxt = {byte_data[0], ye_r[7:0]}; // [RULE11]
                                end
                            end
                        end
                        default: begin
                            // Parameters of commands outside this block are ignored
                            cmd_nxt = cmd_r;
                        end
                    endcase
                end
                default: begin
                    state_nxt = ram_addr_pkg::ST_IDLE;
                end
            endcase
        end
        // Registered copy of the write state so the level leaves from a flop
        wr_open_nxt = (state_nxt == ram_addr_pkg::ST_WRITE); // [RULE3]
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_r <= ram_addr_pkg::ST_IDLE;
            cmd_r <= 8'h00;
            pidx_r <= ram_addr_pkg::PIDX_0;
            x_r <= ram_addr_pkg::RST_HORIZ_POS; // [RULE1]
            y_r <= ram_addr_pkg::RST_VERT_POS; // [RULE2]
            mode_r <= ram_addr_pkg::RST_ENTRY_MODE; // [RULE4]
            xs_r <= ram_addr_pkg::RST_HORIZ_START; // [RULE10]
            xe_r <= ram_addr_pkg::RST_HORIZ_END; // [RULE10]
            ys_r <= ram_addr_pkg::RST_VERT_START; // [RULE11]
            ye_r <= ram_addr_pkg::RST_VERT_END; // [RULE11]
            plane_r <= 1'b0;
            wr_r <= 1'b0;
            wdata_r <= 8'h00;
            wx_r <= ram_addr_pkg::RST_HORIZ_POS;
            wy_r <= ram_addr_pkg::RST_VERT_POS;
            wr_open_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cmd_r <= cmd_nxt;
            pidx_r <= pidx_nxt;
            x_r <= x_nxt;
            y_r <= y_nxt;
            mode_r <= mode_nxt;
            xs_r <= xs_nxt;
            xe_r <= xe_nxt;
            ys_r <= ys_nxt;
            ye_r <= ye_nxt;
            plane_r <= plane_nxt;
            wr_r <= wr_nxt;
            wdata_r <= wdata_nxt;
            wx_r <= wx_nxt;
            wy_r <= wy_nxt;
            wr_open_r <= wr_open_nxt;
        end
    end

    // Every output is a flop; write address is the pre-step position
    assign ram_wr = wr_r;
    assign ram_wr_plane = plane_r;
    assign ram_wr_data = wdata_r;
    assign ram_wr_x = wx_r;
    assign ram_wr_y = wy_r;
    assign horiz_pos = x_r;
    assign vert_pos = y_r;
    assign entry_mode = mode_r;
    assign write_active = wr_open_r;
endmodule

// ===== bench/ram_position_counter_assertions.sv
// Checker for the RAM address counter, bound to its top module.
// Assumes one clock and a synchronous active low reset.
module ram_position_counter_assertions (
    input wire logic clk,
    input wire logic rstn,
    input wire logic byte_valid,
    input wire logic [7:0] byte_data,
    input wire logic byte_is_data,
    input wire logic ram_wr,
    input wire logic [7:0] ram_wr_data,
    input wire logic [ram_addr_pkg::XW-1:0] ram_wr_x,
    input wire logic [ram_addr_pkg::YW-1:0] ram_wr_y,
    input wire logic [ram_addr_pkg::XW-1:0] horiz_pos,
    input wire logic [ram_addr_pkg::YW-1:0] vert_pos,
    input wire logic [ram_addr_pkg::MODE_W-1:0] entry_mode,
    input wire logic write_active
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] last_cmd_r;
    logic [1:0] pcnt_r;
    logic [5:0] hx_start_r;
    logic [5:0] hx_end_r;
    // Shadow of the command parser so parameter bytes can be told apart
    always_ff @(posedge clk) begin
        if (!rstn) begin
            last_cmd_r <= 8'h00;
            pcnt_r <= 2'h0;
            hx_start_r <= ram_addr_pkg::RST_HORIZ_START;
            hx_end_r <= ram_addr_pkg::RST_HORIZ_END;
        end else if (byte_valid && !byte_is_data) begin
            last_cmd_r <= byte_data;
            pcnt_r <= 2'h0;
        end else if (byte_valid) begin
            pcnt_r <= pcnt_r + 2'h1;
            if (last_cmd_r == ram_addr_pkg::CMD_HORIZ_WIN && pcnt_r == 2'h0) hx_start_r <= byte_data[5:0];
            if (last_cmd_r == ram_addr_pkg::CMD_HORIZ_WIN && pcnt_r == 2'h1) hx_end_r <= byte_data[5:0];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence param_of(logic [7:0] c, logic [1:0] n);
        byte_valid && byte_is_data && last_cmd_r == c && pcnt_r == n;
    endsequence
    sequence nop_in;
        byte_valid && !byte_is_data && byte_data == ram_addr_pkg::CMD_NO_OPERATION;
    endsequence
    a_horiz_load: assert property (
        param_of(ram_addr_pkg::CMD_HORIZ_POS, 2'h0) |=> horiz_pos == $past(byte_data[5:0]))
        else $error("horizontal position not loaded");
    a_vert_low: assert property (
        param_of(ram_addr_pkg::CMD_VERT_POS, 2'h0) |=> vert_pos[7:0] == $past(byte_data))
        else $error("vertical low bits not loaded");
    a_vert_high: assert property (
        param_of(ram_addr_pkg::CMD_VERT_POS, 2'h1) |=> vert_pos[8] == $past(byte_data[0]))
        else $error("vertical high bit not loaded");
    a_mode_load: assert property (
        param_of(ram_addr_pkg::CMD_ENTRY_MODE, 2'h0) |=> entry_mode == $past(byte_data[2:0]))
        else $error("entry setting not loaded");
    a_nop_ends: assert property (nop_in |=> !write_active)
        else $error("write sequence survived no-operation");
    a_nop_keeps: assert property (
        nop_in |=> $stable(entry_mode) && $stable(horiz_pos) && $stable(vert_pos))
        else $error("no-operation changed state");
    a_wr_cause: assert property (ram_wr |-> $past(byte_valid && byte_is_data && write_active))
        else $error("write without data byte");
    a_wr_data: assert property (
        byte_valid && byte_is_data && write_active |=> ram_wr && ram_wr_data == $past(byte_data))
        else $error("data byte not written");
    a_horiz_inc: assert property (
        ram_wr && !entry_mode[2] && entry_mode[0] && ram_wr_x != hx_end_r
        |-> horiz_pos == ram_wr_x + 6'h01 && vert_pos == ram_wr_y)
        else $error("horizontal increment wrong");
    a_horiz_dec: assert property (
        ram_wr && !entry_mode[2] && !entry_mode[0] && ram_wr_x != hx_start_r
        |-> horiz_pos == ram_wr_x - 6'h01 && vert_pos == ram_wr_y)
        else $error("horizontal decrement wrong");
endmodule

bind ram_position_counter ram_position_counter_assertions i_ram_position_counter_assertions (.clk(clk), .rstn(rstn),
    .byte_valid(byte_valid), .byte_data(byte_data), .byte_is_data(byte_is_data), .ram_wr(ram_wr),
    .ram_wr_data(ram_wr_data), .ram_wr_x(ram_wr_x), .ram_wr_y(ram_wr_y), .horiz_pos(horiz_pos),
    .vert_pos(vert_pos), .entry_mode(entry_mode), .write_active(write_active));

// ===== bench/host_model.sv
// Host side: hands deserialised command and parameter bytes to the counter.
// Assumes the caller sits at a falling edge of clk.
module host_model (
    input wire logic clk,
    output logic byte_valid,
    output logic [7:0] byte_data,
    output logic byte_is_data
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        byte_valid = 1'b0;
        byte_data = 8'h00;
        byte_is_data = 1'b0;
    end
    // Holds the byte for one taking edge; the caller releases with idle
    task automatic send(input logic [7:0] d, input logic is_data);
        byte_valid = 1'b1;
        byte_data = d;
        byte_is_data = is_data;
        @(negedge clk);
    endtask
    // Released lines show the inverse so stale values cannot pass
    task automatic idle();
        byte_valid = 1'b0;
        byte_data = ~byte_data;
        byte_is_data = ~byte_is_data;
        @(negedge clk);
    endtask
endmodule

// ===== bench/test_display_ram_address_counter.sv
// Self-checking bench for the RAM address counter.
// Assumes the host model drives every byte at a falling edge.
module test_display_ram_address_counter;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic byte_valid, byte_is_data, ram_wr, ram_wr_plane, write_active;
    logic [7:0] byte_data, ram_wr_data;
    logic [5:0] ram_wr_x, horiz_pos;
    logic [8:0] ram_wr_y, vert_pos;
    logic [2:0] entry_mode;
    int mismatches = 0;
    int total_checks = 0;
    always #20 clk = ~clk;
    host_model i_host_model (.clk(clk), .byte_valid(byte_valid), .byte_data(byte_data), .byte_is_data(byte_is_data));
    ram_position_counter i_ram_position_counter (.clk(clk), .rstn(rstn), .byte_valid(byte_valid),
        .byte_data(byte_data), .byte_is_data(byte_is_data), .ram_wr(ram_wr), .ram_wr_plane(ram_wr_plane),
        .ram_wr_data(ram_wr_data), .ram_wr_x(ram_wr_x), .ram_wr_y(ram_wr_y), .horiz_pos(horiz_pos),
        .vert_pos(vert_pos), .entry_mode(entry_mode), .write_active(write_active));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t ns seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    function automatic logic [8:0] step9(input logic [8:0] v, input logic inc, input logic [8:0] s, input logic [8:0] e);
        if (v == (inc ? e : s)) return inc ? s : e;
        return inc ? v + 9'h001 : v - 9'h001;
    endfunction
    task automatic do_reset();
        rstn = 1'b0;
        repeat (3) @(negedge clk);
        rstn = 1'b1;
        check(16'(entry_mode), 16'h0003);
        check(16'(horiz_pos), 16'h0000);
        check(16'(vert_pos), 16'h0000);
        check(16'(write_active), 16'h0000);
    endtask
    task automatic t_load();
        i_host_model.send(ram_addr_pkg::CMD_HORIZ_POS, 1'b0);
        i_host_model.send(8'hc5, 1'b1);
        check(16'(horiz_pos), 16'h0005);
        i_host_model.send(ram_addr_pkg::CMD_VERT_POS, 1'b0);
        i_host_model.send(8'h34, 1'b1);
        i_host_model.send(8'h01, 1'b1);
        i_host_model.idle();
        check(16'(vert_pos), 16'h0134);
    endtask
    // Walks a 2 by 2 window once round and back to its first corner
    task automatic t_walk(input logic [2:0] m);
        logic [8:0] x, y, nx, ny;
        int k;
        i_host_model.send(ram_addr_pkg::CMD_ENTRY_MODE, 1'b0);
        i_host_model.send({5'h00, m}, 1'b1);
        check(16'(entry_mode), 16'(m));
        i_host_model.send(ram_addr_pkg::CMD_HORIZ_WIN, 1'b0);
        i_host_model.send(8'h02, 1'b1);
        i_host_model.send(8'h03, 1'b1);
        i_host_model.send(ram_addr_pkg::CMD_VERT_WIN, 1'b0);
        i_host_model.send(8'h05, 1'b1);
        i_host_model.send(8'h00, 1'b1);
        i_host_model.send(8'h06, 1'b1);
        i_host_model.send(8'h00, 1'b1);
        x = m[0] ? 9'h002 : 9'h003;
        y = m[1] ? 9'h005 : 9'h006;
        i_host_model.send(ram_addr_pkg::CMD_HORIZ_POS, 1'b0);
        i_host_model.send(x[7:0], 1'b1);
        i_host_model.send(ram_addr_pkg::CMD_VERT_POS, 1'b0);
        i_host_model.send(y[7:0], 1'b1);
        i_host_model.send(8'h00, 1'b1);
        i_host_model.send(m[0] ? ram_addr_pkg::CMD_WRITE_PLANE1 : ram_addr_pkg::CMD_WRITE_PLANE0, 1'b0);
        for (k = 0; k < 5; k++) begin
            i_host_model.send(8'h30 + 8'(k), 1'b1);
            check(16'(ram_wr), 16'h0001);
            check(16'(ram_wr_data), 16'h0030 + 16'(k));
            check(16'(ram_wr_plane), 16'(m[0]));
            check(16'(ram_wr_x), 16'(x));
            check(16'(ram_wr_y), 16'(y));
            nx = step9(x, m[0], 9'h002, 9'h003);
            ny = step9(y, m[1], 9'h005, 9'h006);
            if (!m[2]) begin
                if (x == (m[0] ? 9'h003 : 9'h002)) y = ny;
                x = nx;
            end else begin
                if (y == (m[1] ? 9'h006 : 9'h005)) x = nx;
                y = ny;
            end
        end
        i_host_model.idle();
    endtask
    task automatic t_nop();
        i_host_model.send(ram_addr_pkg::CMD_WRITE_PLANE0, 1'b0);
        check(16'(write_active), 16'h0001);
        i_host_model.send(ram_addr_pkg::CMD_NO_OPERATION, 1'b0);
        check(16'(write_active), 16'h0000);
        i_host_model.send(8'haa, 1'b1);
        check(16'(ram_wr), 16'h0000);
        check(16'(entry_mode), 16'h0007);
        i_host_model.idle();
    endtask
    // Power-on windows: a write at the last column and row wraps both axes home
    task automatic t_por_window();
        i_host_model.send(8'h3c, 1'b0);
        i_host_model.send(8'h11, 1'b1);
        check(16'(horiz_pos), 16'h0000);
        i_host_model.send(ram_addr_pkg::CMD_HORIZ_POS, 1'b0);
        i_host_model.send(8'h15, 1'b1);
        i_host_model.send(ram_addr_pkg::CMD_VERT_POS, 1'b0);
        i_host_model.send(8'h27, 1'b1);
        i_host_model.send(8'h01, 1'b1);
        i_host_model.send(ram_addr_pkg::CMD_WRITE_PLANE0, 1'b0);
        i_host_model.send(8'h5a, 1'b1);
        check(16'(ram_wr_x), 16'h0015);
        check(16'(ram_wr_y), 16'h0127);
        i_host_model.send(8'ha5, 1'b1);
        check(16'(ram_wr_x), 16'h0000);
        check(16'(ram_wr_y), 16'h0000);
        check(16'(ram_wr_data), 16'h00a5);
        i_host_model.idle();
    endtask
    initial begin
        #(40 * 4000);
        mismatches++;
        print_verdict();
    end
    initial begin
        @(negedge clk);
        do_reset();
        t_load();
        for (int m = 0; m < 8; m++) t_walk(3'(m));
        t_nop();
        do_reset();
        t_por_window();
        print_verdict();
    end
endmodule
